//--- shared/pipe_map.svh
// constants of the pixel imaging pipeline
`ifndef PIPE_MAP_SVH
`define PIPE_MAP_SVH
`define COMP_W      16
`define FRAC_BITS   14
`define SAT_MAX     40'sh00_0000_7fff
`define SAT_MIN     40'shff_ffff_8000
`define TBL_AW      10
`define TBL_WORDS   1024
`define LUT_BASE1   10'h200
`define HIST_BASE1  10'h200
`define BIN_MAX     16'hffff
`define MAX_TABLES  2'h2
`define DESC_N      4
`define PIX_BYTES   32'h0000_0008
`define PROG_TBL    2'h1
`define FIFO_DEPTH  32
`endif

//--- shared/pipe_pkg.sv
// types of the pixel imaging pipeline
`include "pipe_map.svh"
package pipe_pkg;
	typedef logic signed [`COMP_W-1:0] comp_t;
	typedef struct packed {
		comp_t [3:0] c;
	} pixel_t;
	typedef enum logic [1:0] {K_OFF = 2'b00, K_3 = 2'b01, K_5 = 2'b10, K_7 = 2'b11} ksize_t;
	typedef struct packed {
		logic         int_mode;
		comp_t [3:0]  scale;
		comp_t [3:0]  bias;
		comp_t [15:0] matrix;
		comp_t [6:0]  taps;
		ksize_t       ksize;
		logic [2:0]   tables;
		logic [2:0]   hist_shift;
	} cfg_t;
	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
		logic [31:0] data;
	} prog_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] count;
		logic        last;
	} desc_t;
	typedef enum logic [1:0] {D_IDLE = 2'b00, D_LOAD = 2'b01, D_RUN = 2'b10, D_DONE = 2'b11} dma_state_t;
endpackage : pipe_pkg

//--- logic/pixel_imaging_pipeline.sv
// pixel pipeline with dma channels, table memory and statistics
//
// Behaviour
// - scale each component, then add bias
// - 4x4 matrix transforms each pixel's components
// - matrix coefficients allow swap and replication
// - all operands and results in 16-bit fixed point
// - convolution kernels 3, 5, 7, separable/general
// - histogram counts component values into bins
// - at most 1024 bins of 16 bits
// - track min and max per component
// - tables share one 2048-byte memory
// - over two active tables needs processor assist
// - coefficients fractional within two, or integer
// - each arithmetic stage does all its MACs in one clock
// - two dma channels with own state
// - host, scalar and bitstream units program dma
`timescale 1ns/1ps
`include "pipe_map.svh"

// ----------------------------------------
// fifo
// ----------------------------------------
module pixel_fifo #(
	parameter int W = 64,
	parameter int D = 32
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp;
	logic [AW:0]  rp;

	assign in_ready  = (wp - rp) != (AW+1)'(D);
	assign out_valid = wp != rp;
	assign out_data  = mem[rp[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wp[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp <= wp + 1'b1;
			end
			if (out_valid && out_ready) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule : pixel_fifo

// ----------------------------------------
// dma channel
// ----------------------------------------
module dma_chan
	import pipe_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wr,
	input  wire logic [6:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic        go,
	input  wire logic        ack,
	output logic             req,
	output logic [31:0]      addr,
	output logic             busy,
	output logic             done
);
	desc_t       desc [`DESC_N];
	dma_state_t  state;
	logic [1:0]  idx;
	logic [15:0] cnt;

	// descriptors stay writable while the channel runs
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < `DESC_N; i++) begin
				desc[i] <= '0;
			end
		end else if (wr && waddr[6]) begin
			if (waddr[0]) begin
				desc[waddr[3:2]].count <= wdata[15:0];
				desc[waddr[3:2]].last  <= wdata[31];
			end else begin
				desc[waddr[3:2]].addr <= wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= D_IDLE;
			idx   <= 2'h0;
			cnt   <= 16'h0;
			addr  <= 32'h0;
			req   <= 1'b0;
			done  <= 1'b0;
			busy  <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state)
				D_IDLE: begin
					if (wr && !waddr[6] && wdata[0]) begin
						idx   <= wdata[2:1];
						state <= D_LOAD;
						busy  <= 1'b1;
					end
				end
				D_LOAD: begin
					addr  <= desc[idx].addr;
					cnt   <= desc[idx].count;
					state <= D_RUN;
				end
				D_RUN: begin
					if (req) begin
						if (ack) begin
							req  <= 1'b0;
							addr <= addr + `PIX_BYTES;
							cnt  <= cnt - 16'h1;
						end
					end else if (cnt == 16'h0) begin
						if (desc[idx].last || idx == 2'h3) begin
							state <= D_DONE;
						end else begin
							idx   <= idx + 2'h1;
							state <= D_LOAD;
						end
					end else if (go) begin
						req <= 1'b1;
					end
				end
				D_DONE: begin
					done  <= 1'b1;
					busy  <= 1'b0;
					state <= D_IDLE;
				end
			endcase
		end
	end
endmodule : dma_chan

// ----------------------------------------
// top
// ----------------------------------------
module pixel_imaging_pipeline
	import pipe_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire cfg_t                cfg,
	input  wire prog_t               prog_host,
	input  wire prog_t               prog_scalar,
	input  wire prog_t               prog_bits,
	output logic [2:0]               prog_ack,
	output logic                     mem_rd_req,
	output logic [31:0]              mem_rd_addr,
	input  wire logic                mem_rd_ack,
	input  wire pixel_t              mem_rd_data,
	output logic                     mem_wr_req,
	output logic [31:0]              mem_wr_addr,
	output pixel_t                   mem_wr_data,
	input  wire logic                mem_wr_ack,
	output logic [1:0]               dma_busy,
	output logic [1:0]               dma_done,
	output logic                     assist_needed,
	input  wire logic [`TBL_AW-1:0]  tbl_rd_addr,
	output logic [15:0]              tbl_rd_data,
	input  wire logic                stats_clear,
	output pixel_t                   min_val,
	output pixel_t                   max_val
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// clamp to 16-bit range
	function automatic comp_t sat16(input logic signed [39:0] x);
		if (x > `SAT_MAX) begin
			return comp_t'(`SAT_MAX);
		end else if (x < `SAT_MIN) begin
			return comp_t'(`SAT_MIN);
		end
		return x[15:0];
	endfunction : sat16

	// fraction q2.14 or plain integer coefficients
	function automatic logic signed [39:0] fx(input logic signed [39:0] p, input logic im);
		return im ? p : (p >>> `FRAC_BITS);
	endfunction : fx

	// ----------------------------------------
	// programming ports
	// ----------------------------------------
	prog_t      pw;
	logic [2:0] grant;
	logic [1:0] dwr;

	always_comb begin
		grant = 3'h0;
		pw    = '0;
		if (prog_host.valid && !prog_ack[0]) begin
			grant[0] = 1'b1;
			pw       = prog_host;
		end else if (prog_scalar.valid && !prog_ack[1]) begin
			grant[1] = 1'b1;
			pw       = prog_scalar;
		end else if (prog_bits.valid && !prog_ack[2]) begin
			grant[2] = 1'b1;
			pw       = prog_bits;
		end
	end

	assign dwr[0] = pw.valid && pw.addr[11:8] == 4'h0 && !pw.addr[7];
	assign dwr[1] = pw.valid && pw.addr[11:8] == 4'h0 && pw.addr[7];

	always_ff @(posedge clk) begin
		if (reset) begin
			prog_ack <= 3'h0;
		end else begin
			prog_ack <= grant;
		end
	end

	// ----------------------------------------
	// dma and input buffer
	// ----------------------------------------
	pixel_t f_data;
	logic   f_valid;
	logic   f_ready;
	logic   adv;
	logic   vo;

	dma_chan u_rd (.clk(clk), .reset(reset), .wr(dwr[0]), .waddr(pw.addr[6:0]),
		.wdata(pw.data), .go(f_ready), .ack(mem_rd_ack), .req(mem_rd_req),
		.addr(mem_rd_addr), .busy(dma_busy[0]), .done(dma_done[0]));
	dma_chan u_wr (.clk(clk), .reset(reset), .wr(dwr[1]), .waddr(pw.addr[6:0]),
		.wdata(pw.data), .go(vo), .ack(mem_wr_ack), .req(mem_wr_req),
		.addr(mem_wr_addr), .busy(dma_busy[1]), .done(dma_done[1]));

	// read data lands only when the read channel has a request out
	pixel_fifo #(.W($bits(pixel_t)), .D(`FIFO_DEPTH)) u_fifo (.clk(clk), .reset(reset),
		.in_valid(mem_rd_req && mem_rd_ack), .in_ready(f_ready), .in_data(mem_rd_data),
		.out_valid(f_valid), .out_ready(adv), .out_data(f_data));

	// ----------------------------------------
	// arithmetic stages
	// ----------------------------------------
	pixel_t             s1;
	pixel_t             s2;
	pixel_t             s3;
	pixel_t             hwin [1:6];
	logic               v1;
	logic               v2;
	logic               v3;
	pixel_t             next_s1;
	pixel_t             next_s2;
	pixel_t             next_s3;
	logic signed [39:0] acc;
	int                 ntap;

	// whole pipe moves together; write side stalls it
	assign adv = !vo || (mem_wr_req && mem_wr_ack);

	// 16-bit operands, wide accumulate, 16-bit result
	always_comb begin
		acc  = '0;
		ntap = (cfg.ksize == K_7) ? 7 : (cfg.ksize == K_5) ? 5 : 3;
		for (int k = 0; k < 4; k++) begin
			acc = fx(40'(f_data.c[k]) * 40'(cfg.scale[k]), cfg.int_mode);
			next_s1.c[k] = sat16(acc + 40'(cfg.bias[k]));
		end
		for (int i = 0; i < 4; i++) begin
			acc = '0;
			for (int j = 0; j < 4; j++) begin
				acc = acc + 40'(cfg.matrix[i*4+j]) * 40'(s1.c[j]);
			end
			next_s2.c[i] = sat16(fx(acc, cfg.int_mode));
		end
		// kernel rows; 2d done as passes
		for (int k = 0; k < 4; k++) begin
			acc = 40'(cfg.taps[0]) * 40'(s2.c[k]);
			for (int t = 1; t < 7; t++) begin
				if (t < ntap) begin
					acc = acc + 40'(cfg.taps[t]) * 40'(hwin[t].c[k]);
				end
			end
			next_s3.c[k] = (cfg.ksize == K_OFF) ? s2.c[k] : sat16(fx(acc, cfg.int_mode));
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			v1 <= 1'b0;
			v2 <= 1'b0;
			v3 <= 1'b0;
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			for (int t = 1; t < 7; t++) begin
				hwin[t] <= '0;
			end
		end else if (adv) begin
			v1 <= f_valid;
			v2 <= v1;
			v3 <= v2;
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
			if (v2) begin
				hwin[1] <= s2;
				for (int t = 2; t < 7; t++) begin
					hwin[t] <= hwin[t-1];
				end
			end
		end
	end

	// ----------------------------------------
	// table memory, luts and histogram
	// ----------------------------------------
	// 1024 x 16 bits holds both luts or bins
	logic [15:0]       tmem [`TBL_WORDS];
	logic [2:0]        act;
	logic [1:0]        nact;
	pixel_t            next_out;
	logic [9:0]        li;
	logic [`TBL_AW-1:0] hadr [4];
	logic [7:0]        hv;

	// beyond two tables nothing is accelerated
	assign nact = 2'(cfg.tables[0]) + 2'(cfg.tables[1]) + 2'(cfg.tables[2]);
	assign act  = (nact > `MAX_TABLES) ? 3'h0 : cfg.tables;

	always_comb begin
		next_out = s3;
		for (int k = 0; k < 4; k++) begin
			li = {2'(k), s3.c[k][7:0]};
			if (act[0]) begin
				next_out.c[k] = comp_t'(li[0] ? tmem[li[9:1]][15:8] : tmem[li[9:1]][7:0]);
			end
			li = {2'(k), next_out.c[k][7:0]};
			if (act[1]) begin
				next_out.c[k] = comp_t'(li[0] ? tmem[`LUT_BASE1 + 10'(li[9:1])][15:8]
					: tmem[`LUT_BASE1 + 10'(li[9:1])][7:0]);
			end
			// bins: 256 per component alone, 128 when shared
			hv = next_out.c[k][7:0] >> cfg.hist_shift;
			if (act[1:0] == 2'h0) begin
				hadr[k] = {2'(k), hv};
			end else begin
				hadr[k] = (act[0] ? `HIST_BASE1 : 10'h0) + {1'b0, 2'(k), hv[7:1]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (adv && v3 && act[2]) begin
			for (int k = 0; k < 4; k++) begin
				if (tmem[hadr[k]] != `BIN_MAX) begin
					tmem[hadr[k]] <= tmem[hadr[k]] + 16'h1;
				end
			end
		end
		if (pw.valid && pw.addr[11:10] == `PROG_TBL) begin
			tmem[pw.addr[9:0]] <= pw.data[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tbl_rd_data <= 16'h0;
		end else begin
			tbl_rd_data <= tmem[tbl_rd_addr];
		end
	end

	// ----------------------------------------
	// output and statistics
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			vo            <= 1'b0;
			mem_wr_data   <= '0;
			assist_needed <= 1'b0;
		end else begin
			assist_needed <= nact > `MAX_TABLES;
			if (adv) begin
				vo          <= v3;
				mem_wr_data <= next_out;
			end
		end
	end

	// running min and max per component
	always_ff @(posedge clk) begin
		if (reset || stats_clear) begin
			for (int k = 0; k < 4; k++) begin
				min_val.c[k] <= comp_t'(`SAT_MAX);
				max_val.c[k] <= comp_t'(`SAT_MIN);
			end
		end else if (adv && v3) begin
			for (int k = 0; k < 4; k++) begin
				if (next_out.c[k] < min_val.c[k]) begin
					min_val.c[k] <= next_out.c[k];
				end
				if (next_out.c[k] > max_val.c[k]) begin
					max_val.c[k] <= next_out.c[k];
				end
			end
		end
	end
endmodule : pixel_imaging_pipeline

//--- tb/pixel_imaging_pipeline_chk.sv
// port checker of the pixel imaging pipeline
`timescale 1ns/1ps
module pipe_chk
	import pipe_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire cfg_t        cfg,
	input wire prog_t       prog_host,
	input wire logic [2:0]  prog_ack,
	input wire logic        mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	input wire logic        mem_rd_ack,
	input wire logic        mem_wr_req,
	input wire pixel_t      mem_wr_data,
	input wire logic        mem_wr_ack,
	input wire logic [1:0]  dma_busy,
	input wire logic [1:0]  dma_done,
	input wire logic        assist_needed,
	input wire logic        stats_clear,
	input wire pixel_t      min_val,
	input wire pixel_t      max_val
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_ack_cause: assert property ($rose(prog_ack[0]) |-> $past(prog_host.valid))
		else $error("host ack without request");
	a_ack_pulse: assert property (prog_ack[0] |=> !prog_ack[0])
		else $error("host ack longer than one cycle");
	a_assist_flag: assert property (!$past(reset) && $stable(cfg.tables) |->
		assist_needed == (&cfg.tables))
		else $error("assist flag wrong");
	a_rd_hold: assert property (mem_rd_req && !mem_rd_ack |=>
		mem_rd_req && $stable(mem_rd_addr))
		else $error("read request dropped early");
	a_wr_hold: assert property (mem_wr_req && !mem_wr_ack |=>
		mem_wr_req && $stable(mem_wr_data))
		else $error("write request dropped early");
	a_done_pulse: assert property (dma_done != 2'b00 |->
		(dma_busy & dma_done) == 2'b00 ##1 (dma_done & $past(dma_done)) == 2'b00)
		else $error("done pulse wrong");
	a_req_busy: assert property ((!mem_rd_req || dma_busy[0]) &&
		(!mem_wr_req || dma_busy[1]))
		else $error("request while channel idle");
	a_stats_clear: assert property (stats_clear |=> min_val == {4{16'h7fff}} &&
		max_val == {4{16'h8000}})
		else $error("statistics not cleared");
	a_minmax_mono: assert property (!$past(reset) && !$past(stats_clear) |->
		min_val.c[0] <= $past(min_val.c[0]) && max_val.c[0] >= $past(max_val.c[0]))
		else $error("min or max moved the wrong way");
endmodule : pipe_chk

bind pixel_imaging_pipeline pipe_chk u_pipe_chk (.*);

//--- tb/mem_model.sv
// system memory model answering both dma channels
`timescale 1ns/1ps
module mem_model
	import pipe_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [1:0]  slow,
	input  wire logic        rd_req,
	input  wire logic [31:0] rd_addr,
	output logic             rd_ack,
	output pixel_t           rd_data,
	input  wire logic        wr_req,
	input  wire logic [31:0] wr_addr,
	input  wire pixel_t      wr_data,
	output logic             wr_ack
);
	pixel_t mem [0:127];
	int     rw = 0;
	int     ww = 0;
	logic   rgo;
	initial begin
		rd_ack = 1'b0;
		wr_ack = 1'b0;
		rd_data = '0;
	end
	// idle data bus toggles so a stale word is never seen as valid
	always @(negedge clk) begin
		rgo = rd_req && !rd_ack && rw >= (slow[0] ? 5 : 0);
		rw = (rd_req && !rd_ack && !rgo) ? rw + 1 : 0;
		rd_ack <= rgo;
		rd_data <= rgo ? mem[rd_addr[9:3]] : ~rd_data;
		if (wr_req && !wr_ack && ww >= (slow[1] ? 5 : 0)) begin
			wr_ack <= 1'b1;
			mem[wr_addr[9:3]] <= wr_data;
			ww = 0;
		end else begin
			wr_ack <= 1'b0;
			ww = (wr_req && !wr_ack) ? ww + 1 : 0;
		end
	end
endmodule : mem_model

//--- tb/tb_pixel_imaging_pipeline.sv
// testbench of the pixel imaging pipeline
`timescale 1ns/1ps
module tb_pixel_imaging_pipeline
	import pipe_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	cfg_t        cfg = '0;
	prog_t       pr [3] = '{3{'0}};
	logic [2:0]  prog_ack;
	logic        rd_req, rd_ack, wr_req, wr_ack, assist_needed;
	logic        stats_clear = 1'b0;
	logic [31:0] rd_addr, wr_addr;
	pixel_t      rd_data, wr_data, min_val, max_val;
	logic [1:0]  slow = 2'b00;
	logic [1:0]  dma_busy, dma_done;
	logic [9:0]  tbl_addr = '0;
	logic [15:0] tbl_data;
	int          errors = 0;
	int          n_tests = 0;
	int          k;
	always #12.5 clk = ~clk;

	pixel_imaging_pipeline u_pixel_imaging_pipeline (.clk(clk), .reset(reset), .cfg(cfg),
		.prog_host(pr[0]), .prog_scalar(pr[1]), .prog_bits(pr[2]), .prog_ack(prog_ack),
		.mem_rd_req(rd_req), .mem_rd_addr(rd_addr), .mem_rd_ack(rd_ack),
		.mem_rd_data(rd_data), .mem_wr_req(wr_req), .mem_wr_addr(wr_addr),
		.mem_wr_data(wr_data), .mem_wr_ack(wr_ack), .dma_busy(dma_busy),
		.dma_done(dma_done), .assist_needed(assist_needed), .tbl_rd_addr(tbl_addr),
		.tbl_rd_data(tbl_data), .stats_clear(stats_clear), .min_val(min_val),
		.max_val(max_val));
	mem_model u_mem_model (.clk(clk), .slow(slow), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_ack(wr_ack));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task stop_test;
		$display("errors %0d checks %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task lim(input int n);
		if (k >= n) begin
			errors++;
			$display("timeout at %0t", $time);
			stop_test();
		end
	endtask : lim
	task prog(input int s, input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		pr[s] = {1'b1, a, d};
		k = 0;
		do begin @(negedge clk); k++; end while (prog_ack[s] !== 1'b1 && k < 20);
		pr[s].valid = 1'b0;
		lim(20);
	endtask : prog
	// write channel first so it is ready when pixels arrive
	task run(input logic [15:0] n);
		logic [1:0] seen;
		prog(1, 12'h0c0, 32'h200);
		prog(1, 12'h0c1, {16'h8000, n});
		prog(2, 12'h080, 32'h1);
		prog(0, 12'h040, 32'h0);
		prog(0, 12'h041, {16'h8000, n});
		prog(0, 12'h000, 32'h1);
		k = 0;
		seen = 2'b00;
		do begin
			@(negedge clk);
			k++;
			seen = seen | dma_done;
		end while (k < 3 || dma_busy !== 2'b00 && k < 3000);
		lim(3000);
		chk(seen, 2'b11);
	endtask : run
	task base(input logic im);
		cfg = '0;
		cfg.int_mode = im;
		for (int i = 0; i < 4; i++) begin
			cfg.scale[i] = im ? 16'sh0001 : 16'sh4000;
			cfg.matrix[i*5] = cfg.scale[i];
		end
	endtask : base
	function automatic pixel_t mk(input int i);
		return {16'(i), 16'(-i), 16'(i), 16'(-i)};
	endfunction : mk

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_scale;
		base(0);
		cfg.scale = {4{16'sh2000}};
		cfg.bias = 64'h7000_0010_9000_0010;
		u_mem_model.mem[0] = 64'h7000_0100_8000_f000;
		run(1);
		chk(u_mem_model.mem[64], 64'h7fff_0090_8000_f810);
		base(1);
		cfg.scale = {4{16'sh0002}};
		u_mem_model.mem[0] = 64'h0003_fffd_0100_4000;
		run(1);
		chk(u_mem_model.mem[64], 64'h0006_fffa_0200_7fff);
		$display("scale test done");
	endtask : t_scale
	task t_matrix;
		base(0);
		cfg.matrix = '0;
		cfg.matrix[1] = 16'sh4000;
		cfg.matrix[4] = 16'sh4000;
		cfg.matrix[8] = 16'sh4000;
		cfg.matrix[15] = 16'sh4000;
		u_mem_model.mem[0] = 64'h0004_0003_0002_0001;
		run(1);
		chk(u_mem_model.mem[64], 64'h0004_0001_0001_0002);
		$display("matrix test done");
	endtask : t_matrix
	task t_conv;
		base(0);
		cfg.ksize = K_3;
		cfg.taps[0] = 16'sh2000;
		cfg.taps[1] = 16'sh2000;
		slow = 2'b11;
		u_mem_model.mem[0] = {4{16'h0010}};
		u_mem_model.mem[1] = {4{16'h0030}};
		run(2);
		chk(u_mem_model.mem[65], {4{16'h0020}});
		slow = 2'b00;
		// longer kernels reach four and six pixels back
		cfg.taps = '0;
		for (int i = 0; i < 7; i++)
			u_mem_model.mem[i] = mk(i + 1);
		cfg.ksize = K_5;
		cfg.taps[4] = 16'sh4000;
		run(7);
		chk(u_mem_model.mem[70], mk(3));
		cfg.ksize = K_7;
		cfg.taps[6] = 16'sh4000;
		run(7);
		chk(u_mem_model.mem[70], mk(4));
		$display("convolution test done");
	endtask : t_conv
	// slow writes back the stream up into the fifo without filling it
	task t_fill;
		base(0);
		for (int i = 0; i < 40; i++)
			u_mem_model.mem[i] = mk(i);
		stats_clear = 1'b1;
		@(negedge clk);
		stats_clear = 1'b0;
		chk(min_val, {4{16'h7fff}});
		slow = 2'b10;
		run(40);
		slow = 2'b00;
		for (int i = 0; i < 40; i++)
			chk(u_mem_model.mem[64+i], mk(i));
		chk(min_val, 64'h0000_ffd9_0000_ffd9);
		chk(max_val, 64'h0027_0000_0027_0000);
		$display("fill test done");
	endtask : t_fill
	task t_hist;
		base(0);
		cfg.tables = 3'b100;
		@(negedge clk);
		pr[0] = {1'b1, 12'h405, 32'h0000ffff};
		pr[1] = {1'b1, 12'h505, 32'h0};
		k = 0;
		do begin @(negedge clk); k++; end while (prog_ack === 3'b000 && k < 20);
		chk(prog_ack, 3'b001);
		pr[0].valid = 1'b0;
		do begin @(negedge clk); k++; end while (prog_ack[1] !== 1'b1 && k < 20);
		pr[1].valid = 1'b0;
		lim(20);
		prog(2, 12'h605, 32'h0);
		prog(2, 12'h705, 32'h0);
		prog(1, 12'h7ff, 32'h1234);
		u_mem_model.mem[0] = {4{16'h0005}};
		u_mem_model.mem[1] = {4{16'h0005}};
		run(2);
		for (int c = 0; c < 5; c++) begin
			tbl_addr = (c == 4) ? 10'h3ff : 10'(c * 256 + 5);
			repeat (2) @(negedge clk);
			chk(tbl_data, c == 0 ? 16'hffff : c == 4 ? 16'h1234 : 16'h0002);
		end
		$display("histogram test done");
	endtask : t_hist
	// two luts in series, then one lut with shifted bins
	task t_lut;
		base(0);
		for (int c = 0; c < 4; c++) begin
			prog(0, 12'(12'h402 + c * 128), 32'h0900);
			prog(0, 12'(12'h604 + c * 128), 32'h2100);
			prog(0, 12'(12'h602 + c * 128), 32'h0);
		end
		u_mem_model.mem[0] = {4{16'h0005}};
		cfg.tables = 3'b011;
		run(1);
		chk(u_mem_model.mem[64], {4{16'h0021}});
		cfg.tables = 3'b101;
		cfg.hist_shift = 3'h1;
		run(1);
		chk(u_mem_model.mem[64], {4{16'h0009}});
		tbl_addr = 10'h382;
		repeat (2) @(negedge clk);
		chk(tbl_data, 16'h0001);
		$display("lut test done");
	endtask : t_lut
	task t_assist;
		cfg.tables = 3'b111;
		repeat (2) @(negedge clk);
		chk(assist_needed, 1'b1);
		cfg.tables = 3'b011;
		repeat (2) @(negedge clk);
		chk(assist_needed, 1'b0);
		$display("assist test done");
	endtask : t_assist

	initial begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		chk({prog_ack, rd_req, wr_req, dma_busy, dma_done, assist_needed}, '0);
		chk({min_val, max_val}, {{4{16'h7fff}}, {4{16'h8000}}});
		$display("reset test done");
		t_scale;
		t_matrix;
		t_conv;
		t_fill;
		t_hist;
		t_lut;
		t_assist;
		stop_test();
	end
endmodule : tb_pixel_imaging_pipeline
